// >>> lltc_cfg.svh
// Constants for the loopback-two control block
`ifndef LLTC_CFG_SVH
`define LLTC_CFG_SVH
`define LLTC_DATA_W 18
`define LLTC_FIFO_DEPTH 8
`define LLTC_FIFO_AW 3
`define LLTC_ALL_ONES 18'h3FFFF
`define LLTC_ALL_ZERO 18'h00000
`define LLTC_ACT_ON 1'b1
`define LLTC_ACT_OFF 1'b0
`define LLTC_PIN_N 6
`define LLTC_PIN_CMD 5
`define LLTC_PIN_REL 4
`define LLTC_PIN_ACT 3
`define LLTC_PIN_RESP 2
`define LLTC_PIN_LOS 1
`define LLTC_PIN_LFA 0
`endif

// >>> lltc_checker.sv
// Assertions on the ports of the loopback-two control block
`timescale 1ns/10ps
`include "lltc_cfg.svh"
module lltc_checker (
  // Clock, reset and inputs
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic loop2_cmd_in,
  input wire logic user_response_in,
  input wire logic signal_loss_in,
  input wire logic frame_align_loss_in,
  input wire logic loop_release_in,
  // Outputs
  input wire logic act_to_exch_out,
  input wire logic [`LLTC_DATA_W-1:0] up_data_out,
  input wire logic echo_zero_out,
  input wire logic user_rx_enable_out,
  input wire lltc_pkg::lltc_user_sig_e user_sig_out,
  input wire lltc_pkg::lltc_state_e state_out
);
  // State decodes; pins pass a two-flop sync, hence the short ranges
  wire in_sync = state_out == lltc_pkg::LLTC_LOOP_SYNCED;
  wire in_rdy = state_out == lltc_pkg::LLTC_LOOP_READY;
  wire in_tr = state_out == lltc_pkg::LLTC_LOOP_TRANSPARENT;
  wire in_loop = in_sync | in_rdy | in_tr;
  wire loss = signal_loss_in | frame_align_loss_in;
  wire quiet = !loss && !loop_release_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////
  // Assertions
  block_user_a: assert property (in_loop |-> !user_rx_enable_out)
    else $error("user side open in loop");
  synced_out_a: assert property (in_sync |-> !act_to_exch_out &&
    user_sig_out == lltc_pkg::LLTC_USER_SYNC_SIGNAL) else $error("bad synced outputs");
  ready_act_a: assert property (in_rdy |-> act_to_exch_out)
    else $error("ready bit low in loop ready");
  transp_sig_a: assert property (in_tr |-> echo_zero_out &&
    user_sig_out == lltc_pkg::LLTC_USER_ACTIVE_SIGNAL) else $error("bad transparent outputs");
  synced_ones_a: assert property (in_sync && $past(in_sync)
    |-> up_data_out == `LLTC_ALL_ONES) else $error("upstream not all ones");
  cmd_enter_a: assert property ($rose(loop2_cmd_in) && !in_loop
    |-> ##[2:4] in_sync) else $error("command not taken");
  // A clean response seen at the pin for three edges must move the state on
  resp_ready_a: assert property ((in_sync && user_response_in && quiet) [*3]
    |=> in_rdy) else $error("no loop ready on response");
  loss_exit_a: assert property ((in_rdy || in_tr) && loss && !loop_release_in
    |-> ##[1:4] in_sync) else $error("loss not handled");
  // Main scenarios
  cover property (in_tr);
  cover property (in_sync ##1 in_rdy);
  cover property (state_out == lltc_pkg::LLTC_FULLY_ACTIVE ##[1:4] in_sync);
endmodule : lltc_checker
bind lltc_ctrl lltc_checker chk_u (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .loop2_cmd_in(loop2_cmd_in),
  .user_response_in(user_response_in),
  .signal_loss_in(signal_loss_in),
  .frame_align_loss_in(frame_align_loss_in),
  .loop_release_in(loop_release_in),
  .act_to_exch_out(act_to_exch_out),
  .up_data_out(up_data_out),
  .echo_zero_out(echo_zero_out),
  .user_rx_enable_out(user_rx_enable_out),
  .user_sig_out(user_sig_out),
  .state_out(state_out)
);

// >>> lltc_ctrl.sv
// Loopback-two activation control for the customer-side transceiver
`timescale 1ns/10ps
`include "lltc_cfg.svh"
module lltc_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Line side status and commands (pins, synchronised here)
  input wire logic loop2_cmd_in,
  input wire logic loop_release_in,
  input wire logic act_from_exch_in,
  // Four-wire receiver status (pins, synchronised here)
  input wire logic user_response_in,
  input wire logic signal_loss_in,
  input wire logic frame_align_loss_in,
  // Downstream B/D data from exchange side (same clock)
  input wire logic [`LLTC_DATA_W-1:0] down_data_in,
  input wire logic down_valid_in,
  output logic down_ready_out,
  // Upstream B/D data from user terminal (same clock)
  input wire logic [`LLTC_DATA_W-1:0] user_data_in,
  input wire logic user_valid_in,
  // Outputs toward exchange side
  output logic act_to_exch_out,
  output logic [`LLTC_DATA_W-1:0] up_data_out,
  output logic up_valid_out,
  // Outputs toward user terminal
  output lltc_pkg::lltc_user_sig_e user_sig_out,
  output logic echo_zero_out,
  output logic [`LLTC_DATA_W-1:0] user_tx_data_out,
  output logic user_rx_enable_out,
  output lltc_pkg::lltc_state_e state_out
);
  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for pin inputs
  logic [`LLTC_PIN_N-1:0] sync1_reg;
  logic [`LLTC_PIN_N-1:0] sync2_reg;
  wire [`LLTC_PIN_N-1:0] pins = {loop2_cmd_in, loop_release_in, act_from_exch_in,
                                 user_response_in, signal_loss_in, frame_align_loss_in};
  genvar gi;
  generate
    for (gi = 0; gi < `LLTC_PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  wire loop_cmd = sync2_reg[`LLTC_PIN_CMD];
  wire loop_rel = sync2_reg[`LLTC_PIN_REL];
  wire act_rx = sync2_reg[`LLTC_PIN_ACT];
  wire resp = sync2_reg[`LLTC_PIN_RESP];
  wire los_lfa = sync2_reg[`LLTC_PIN_LOS] | sync2_reg[`LLTC_PIN_LFA];

  ////////////////////////////////////////////////////////////////////////
  // State machine
  lltc_pkg::lltc_state_e state_reg;
  lltc_pkg::lltc_state_e state_next;
  logic cmd_d_reg;
  wire cmd_rise = loop_cmd && !cmd_d_reg;
  wire in_loop = (state_reg == lltc_pkg::LLTC_LOOP_SYNCED) ||
                 (state_reg == lltc_pkg::LLTC_LOOP_READY) ||
                 (state_reg == lltc_pkg::LLTC_LOOP_TRANSPARENT);
  // Self lock only counts while the receiver reports no loss; otherwise a
  // held response and a held loss would bounce between ready and synced
  wire resp_locked = resp && !los_lfa;

  always_comb
  begin
    state_next = state_reg;
    if (cmd_rise && !in_loop)
    begin
      state_next = lltc_pkg::LLTC_LOOP_SYNCED;
    end
    else if (loop_rel && in_loop)
      state_next = lltc_pkg::LLTC_SYNCED;
    else
    begin
      unique case (state_reg)
        lltc_pkg::LLTC_SYNCED:
          if (resp)
            state_next = lltc_pkg::LLTC_USER_READY;
        lltc_pkg::LLTC_USER_READY:
          if (act_rx)
            state_next = lltc_pkg::LLTC_FULLY_ACTIVE;
        lltc_pkg::LLTC_FULLY_ACTIVE:
          state_next = state_reg;
        lltc_pkg::LLTC_LOOP_SYNCED:
          if (resp_locked)
            state_next = lltc_pkg::LLTC_LOOP_READY;
        lltc_pkg::LLTC_LOOP_READY:
          if (los_lfa)
            state_next = lltc_pkg::LLTC_LOOP_SYNCED;
          else if (act_rx)
            state_next = lltc_pkg::LLTC_LOOP_TRANSPARENT;
        lltc_pkg::LLTC_LOOP_TRANSPARENT:
          if (los_lfa)
            state_next = lltc_pkg::LLTC_LOOP_SYNCED;
        // Two codes of the state word are unused; recover to the idle state
        default:
          state_next = lltc_pkg::LLTC_SYNCED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output decode from next state so outputs stay registered
  wire nx_user_ready = (state_next == lltc_pkg::LLTC_USER_READY);
  wire nx_active = (state_next == lltc_pkg::LLTC_FULLY_ACTIVE);
  wire nx_synced = (state_next == lltc_pkg::LLTC_LOOP_SYNCED);
  wire nx_ready = (state_next == lltc_pkg::LLTC_LOOP_READY);
  wire nx_trans = (state_next == lltc_pkg::LLTC_LOOP_TRANSPARENT);
  wire nx_loop = nx_synced || nx_ready || nx_trans;
  // Activation-ready follows state; loop-synced always sends zero
  wire act_high = nx_user_ready || nx_active || nx_ready || nx_trans;
  wire act_next = act_high ? `LLTC_ACT_ON : `LLTC_ACT_OFF;
  // Active signal when transparent or fully active; sync signal in every other state, loop-synced included
  wire sig_active = nx_trans || nx_active;
  wire lltc_pkg::lltc_user_sig_e sig_next =
    sig_active ? lltc_pkg::LLTC_USER_ACTIVE_SIGNAL : lltc_pkg::LLTC_USER_SYNC_SIGNAL;

  ////////////////////////////////////////////////////////////////////////
  // Downstream data buffered; drains every cycle so back-pressure is honest
  logic [`LLTC_DATA_W-1:0] fifo_data;
  logic fifo_valid;
  lltc_fifo #(
    .WIDTH(`LLTC_DATA_W),
    .DEPTH(`LLTC_FIFO_DEPTH),
    .AW(`LLTC_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .flush_in(1'b0),
    .wr_valid_in(down_valid_in),
    .wr_ready_out(down_ready_out),
    .wr_data_in(down_data_in),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(1'b1),
    .rd_data_out(fifo_data)
  );
  // Exchange data toward user and back
  wire [`LLTC_DATA_W-1:0] user_tx_next = fifo_valid ? fifo_data : user_tx_data_out;
  // Loop-ready and transparent send user-bound data upstream; loop-synced sends all ones
  wire [`LLTC_DATA_W-1:0] up_next =
    (nx_ready || nx_trans) ? user_tx_next :
    (nx_loop ? `LLTC_ALL_ONES : user_data_in);
  wire up_valid_next = nx_loop ? fifo_valid : user_valid_in;

  ////////////////////////////////////////////////////////////////////////
  // State register and command edge detector; pin changes reach the
  // outputs three edges later, two for the synchroniser and one here
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= lltc_pkg::LLTC_SYNCED;
      cmd_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_d_reg <= loop_cmd;
    end
  end

  // Status outputs toward both sides
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      act_to_exch_out <= `LLTC_ACT_OFF;
      user_sig_out <= lltc_pkg::LLTC_USER_SYNC_SIGNAL;
      echo_zero_out <= 1'b0;
      user_rx_enable_out <= 1'b1;
      state_out <= lltc_pkg::LLTC_SYNCED;
    end
    else
    begin
      act_to_exch_out <= act_next;
      user_sig_out <= sig_next;
      echo_zero_out <= nx_trans;
      user_rx_enable_out <= !nx_loop;
      state_out <= state_next;
    end
  end

  // Data outputs; reset shows all ones upstream like an idle line
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      up_data_out <= `LLTC_ALL_ONES;
      up_valid_out <= 1'b0;
      user_tx_data_out <= `LLTC_ALL_ZERO;
    end
    else
    begin
      up_data_out <= up_next;
      up_valid_out <= up_valid_next;
      user_tx_data_out <= user_tx_next;
    end
  end
endmodule : lltc_ctrl

// >>> lltc_exch_model.sv
// Exchange-side transceiver model for the line side
`timescale 1ns/10ps
`include "lltc_cfg.svh"
module lltc_exch_model #(
  parameter int CONF_DLY = 12
) (
  // Clock, reset and request
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic req_in,
  // From the customer side
  input wire logic act_in,
  input wire logic ready_in,
  // Toward the customer side
  output logic cmd_out,
  output logic act_out,
  output logic valid_out,
  output logic [`LLTC_DATA_W-1:0] data_out
);
  int cnt;
  // Confirmation is slow on purpose so the customer side must wait
  wire rise = req_in && !cmd_out;
  assign valid_out = !sys_rst_in;
  // command, held ready bit, data counting up while both sides are active
  always_ff @(posedge clk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      cnt <= 0;
      cmd_out <= 1'h0;
      act_out <= 1'h0;
      data_out <= '0;
    end
    else
    begin
      cmd_out <= req_in;
      cnt <= rise ? CONF_DLY : (cnt > 0 ? cnt - 1 : 0);
      act_out <= (rise || cnt > 0) ? 1'h0 : act_in;
      if (ready_in)
        data_out <= (act_in && act_out) ? data_out + 18'h1 : '0;
    end
endmodule : lltc_exch_model

// >>> lltc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`include "lltc_cfg.svh"
module lltc_fifo #(
  parameter int WIDTH = `LLTC_DATA_W,
  parameter int DEPTH = `LLTC_FIFO_DEPTH,
  parameter int AW = `LLTC_FIFO_AW
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic flush_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = wr_valid_in && wr_ready_out;
  wire pop = rd_valid_out && rd_ready_in;
  // Full count sized to the counter, not the pointer, or it wraps to zero
  wire [AW:0] full_count = (AW+1)'(DEPTH);
  wire [AW:0] count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Empty flag decoded; ready is registered so the port comes from a flop
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out = mem[rd_ptr_reg];

  // Storage, no reset needed on data
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr_reg] <= wr_data_in;
  end

  // Pointers and occupancy; flush empties in one cycle
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      wr_ready_out <= 1'b1;
    end
    else if (flush_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      wr_ready_out <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      // Drop ready on the edge that fills the last word
      wr_ready_out <= (count_next != full_count);
    end
  end
endmodule : lltc_fifo

// >>> lltc_pkg.sv
// Types for the loopback-two control block
package lltc_pkg;
  // Customer-side transceiver activation states of interest
  typedef enum logic [2:0] {
    LLTC_SYNCED,
    LLTC_USER_READY,
    LLTC_FULLY_ACTIVE,
    LLTC_LOOP_SYNCED,
    LLTC_LOOP_READY,
    LLTC_LOOP_TRANSPARENT
  } lltc_state_e;
  // Signal sent toward the user terminal
  typedef enum logic [1:0] {
    LLTC_USER_NO_SIGNAL,
    LLTC_USER_SYNC_SIGNAL,
    LLTC_USER_ACTIVE_SIGNAL
  } lltc_user_sig_e;
endpackage : lltc_pkg

// >>> test_line_loopback_two_control.sv
// Testbench for the loopback-two control block
`timescale 1ns/10ps
module test_line_loopback_two_control;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic req = 1'h0;
  logic user_response_in = 1'h0;
  logic loop_release_in = 1'h0;
  logic signal_loss_in = 1'h0;
  logic frame_align_loss_in = 1'h0;
  logic user_valid_in = 1'h1;
  logic [17:0] user_data_in = 18'h2A5A5;
  wire loop2_cmd_in, act_from_exch_in, down_valid_in, down_ready_out;
  wire [17:0] down_data_in, up_data_out, user_tx_data_out;
  wire act_to_exch_out, up_valid_out, echo_zero_out, user_rx_enable_out;
  lltc_pkg::lltc_user_sig_e user_sig_out;
  lltc_pkg::lltc_state_e state_out;
  int failures = 0;
  int n_checks = 0;
  // Clock and the two parties
  always #2.5 clk_in = ~clk_in;
  lltc_ctrl dut_u (.*);
  lltc_exch_model exch_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .act_in(act_to_exch_out), .ready_in(down_ready_out), .cmd_out(loop2_cmd_in),
    .act_out(act_from_exch_in), .valid_out(down_valid_in), .data_out(down_data_in));
  //////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait; a hang ends the run
  task automatic wait_state(input lltc_pkg::lltc_state_e st);
    for (int i = 0; i < 60 && state_out !== st; i++)
      @(posedge clk_in) #1;
    chk(18'(state_out), 18'(st));
    if (state_out !== st)
      tally_and_finish();
  endtask : wait_state
  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic activate;
    user_response_in = 1'h1;
    wait_state(lltc_pkg::LLTC_USER_READY);
    chk(18'(act_to_exch_out), 18'h1);
    wait_state(lltc_pkg::LLTC_FULLY_ACTIVE);
    chk(up_data_out, user_data_in);
    chk(18'(up_valid_out), 18'h1);
    chk(18'(down_ready_out), 18'h1);
    user_valid_in = 1'h0;
    @(posedge clk_in) #1;
    chk(18'(up_valid_out), 18'h0);
    user_valid_in = 1'h1;
  endtask : activate
  task automatic enter_loop;
    req = 1'h1;
    wait_state(lltc_pkg::LLTC_LOOP_SYNCED);
    chk(18'(act_to_exch_out), 18'h0);
    chk(18'(user_sig_out), 18'(lltc_pkg::LLTC_USER_SYNC_SIGNAL));
    chk(18'(user_rx_enable_out), 18'h0);
    chk(up_data_out, 18'h3FFFF);
  endtask : enter_loop
  task automatic go_transparent;
    wait_state(lltc_pkg::LLTC_LOOP_READY);
    chk(18'(act_to_exch_out), 18'h1);
    chk(up_data_out, 18'h0);
    wait_state(lltc_pkg::LLTC_LOOP_TRANSPARENT);
    chk(18'(user_sig_out), 18'(lltc_pkg::LLTC_USER_ACTIVE_SIGNAL));
    chk(18'(echo_zero_out), 18'h1);
    repeat (6) @(posedge clk_in);
    #1;
    chk(18'(user_tx_data_out != 18'h0), 18'h1);
    chk(18'(up_data_out != 18'h0), 18'h1);
    chk(up_data_out, user_tx_data_out);
    chk(18'(up_valid_out), 18'h1);
  endtask : go_transparent
  // Each loss kind in turn, then recovery
  task automatic lose_sync;
    for (int i = 0; i < 2; i++)
    begin
      signal_loss_in = (i == 0);
      frame_align_loss_in = (i == 1);
      wait_state(lltc_pkg::LLTC_LOOP_SYNCED);
      chk(18'(act_to_exch_out), 18'h0);
      chk(18'(user_sig_out), 18'(lltc_pkg::LLTC_USER_SYNC_SIGNAL));
      signal_loss_in = 1'h0;
      frame_align_loss_in = 1'h0;
      wait_state(lltc_pkg::LLTC_LOOP_TRANSPARENT);
    end
  endtask : lose_sync
  task automatic release_loop;
    req = 1'h0;
    loop_release_in = 1'h1;
    wait_state(lltc_pkg::LLTC_SYNCED);
    chk(18'(user_rx_enable_out), 18'h1);
    loop_release_in = 1'h0;
  endtask : release_loop
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    sys_rst_in = 1'h0;
    activate();
    enter_loop();
    go_transparent();
    lose_sync();
    release_loop();
    tally_and_finish();
  end
endmodule : test_line_loopback_two_control
